//--- rtl/vic_controller.sv
//Contract
//- Each source masked by one enable bit
//- Global enable bits zero to six, seven reserved
//- Timer events every 128 us and 1.024 ms
//- Enabled GPIO pins interrupt on both edges
//- Endpoint enables in bits zero to four
//- Reset clears both enable registers
//- Each event latched in own pending flop
//- Pending held until serviced or reset; a one written to its pending bit also clears it
//- Request only when pending and enabled
//- Boot at address zero, two-byte slots
//- Vector address is twice vector number
//- Service starts ten plus five cycles later
//- Output-enable release raises parallel interrupt
//- Strobe release raises parallel interrupt
//- Bus reset event when reset condition ends
//- Endpoint event only on acknowledged last packet
//- Hub event on change, gated babble, gated resume
//- Handshake mode blocks all GPIO pin interrupts
module vic_controller
    import vic_pkg::*;
#(
    parameter int SHORT_PERIOD = SHORT_TIMER_CYC,
    parameter int LONG_PERIOD  = LONG_TIMER_CYC
) (
    input  wire logic                     SYS_CLK,
    input  wire logic                     RESETN,
    input  wire logic [7:0]               ADDR,
    input  wire logic [7:0]               WDATA,
    input  wire logic                     WR_STB,
    input  wire logic                     RD_STB,
    output logic      [7:0]               RDATA,
    input  wire logic                     USB_SE0,
    input  wire logic [NUM_EP-1:0]        EP_PKT_END,
    input  wire logic [NUM_EP-1:0]        EP_ACKED,
    input  wire logic [NUM_HUB_PORTS-1:0] HUB_CONN_CHANGE,
    input  wire logic [NUM_HUB_PORTS-1:0] HUB_BABBLE,
    input  wire logic [NUM_HUB_PORTS-1:0] HUB_RESUME,
    input  wire logic [NUM_HUB_PORTS-1:0] HUB_PORT_EN,
    input  wire logic                     DAC_EVENT,
    input  wire logic                     SERIAL_EVENT,
    input  wire logic [GPIO_PINS-1:0]     GPIO_IN,
    input  wire logic                     OUT_EN_N,
    input  wire logic                     STROBE_IN_N,
    input  wire logic                     CHIP_SEL_N,
    input  wire logic                     INSTR_DONE,
    output logic                          IRQ_REQ,
    output logic                          INT_TAKEN,
    output logic                          VEC_LOAD,
    output logic      [15:0]              VECTOR_ADDR,
    output logic                          ISR_BEGIN,
    output logic                          IRQ_OUT
);

    logic                  rst_q1;
    logic                  rst_n;
    logic [7:0]            global_interrupt_enable;
    logic [7:0]            endpoint_interrupt_enable;
    logic [7:0]            gpio_ie [GPIO_PORTS];
    logic                  hs_mode;
    logic [NUM_SRC-1:0]    pend;
    logic [NUM_SRC-1:0]    en;
    logic [NUM_SRC-1:0]    ev;
    logic [NUM_SRC-1:0]    req;
    logic [NUM_SRC-1:0]    sw_clr;
    logic [NUM_SRC-1:0]    take_clr;
    logic [3:0]            win_idx;
    logic [3:0]            cur_idx;
    logic                  se0_q;
    logic [15:0]           short_cnt;
    logic [15:0]           long_cnt;
    logic                  short_tick;
    logic                  long_tick;
    logic [GPIO_PINS-1:0]  gpio_s1;
    logic [GPIO_PINS-1:0]  gpio_s2;
    logic [GPIO_PINS-1:0]  gpio_s3;
    logic [GPIO_PINS-1:0]  gpio_ie_flat;
    logic [2:0]            hs_s1;
    logic [2:0]            hs_s2;
    logic [2:0]            hs_s3;
    logic                  gpio_ev;
    logic                  hs_ev;
    vic_seq_t              state;
    logic [3:0]            cnt;

    // Lowest set bit wins; used only by the request path, not by status reads
    function automatic logic [3:0] lowest(input logic [NUM_SRC-1:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] slot_addr(input logic [3:0] idx);
        return 16'((32'(idx) + 1) * SLOT_BYTES);
    endfunction

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    // Register writes
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            global_interrupt_enable   <= IE_RESET;
            endpoint_interrupt_enable <= IE_RESET;
            hs_mode                   <= 1'b0;
        end else if (WR_STB) begin
            if (ADDR == GLOBAL_IE_ADDR) begin
                global_interrupt_enable <= WDATA & GLOBAL_IE_MASK;
            end else if (ADDR == EP_IE_ADDR) begin
                endpoint_interrupt_enable <= WDATA & EP_IE_MASK;
            end else if (ADDR == HS_CTRL_ADDR) begin
                hs_mode <= WDATA[HS_MODE_BIT];
            end
        end
    end

    genvar gp;
    generate
        for (gp = 0; gp < GPIO_PORTS; gp++) begin : g_port_ie
            always_ff @(posedge SYS_CLK or negedge rst_n) begin
                if (!rst_n) begin
                    gpio_ie[gp] <= IE_RESET;
                end else if (WR_STB && ADDR == GPIO_IE_BASE + 8'(gp)) begin
                    gpio_ie[gp] <= (gp == GPIO_PORTS - 1) ? (WDATA & PORT3_IE_MASK) : WDATA;
                end
            end
        end
    endgenerate

    assign gpio_ie_flat = GPIO_PINS'({gpio_ie[3], gpio_ie[2], gpio_ie[1], gpio_ie[0]});

    // Read data in the cycle after the strobe; enables for pins are write-only
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            RDATA <= 8'h00;
        end else if (RD_STB) begin
            if (ADDR == GLOBAL_IE_ADDR) begin
                RDATA <= global_interrupt_enable;
            end else if (ADDR == EP_IE_ADDR) begin
                RDATA <= endpoint_interrupt_enable;
            end else if (ADDR == GLOBAL_PEND) begin
                RDATA <= {1'b0, pend[SRC_SERIAL], pend[SRC_GPIO], pend[SRC_DAC], pend[SRC_HUB],
                          pend[SRC_LONG_TMR], pend[SRC_SHORT_TMR], pend[SRC_BUS_RESET]};
            end else if (ADDR == EP_PEND) begin
                RDATA <= {3'b000, pend[SRC_EP_FIRST +: NUM_EP]};
            end else if (ADDR == HS_CTRL_ADDR) begin
                RDATA <= {7'b000_0000, hs_mode};
            end else begin
                RDATA <= 8'h00;
            end
        end else begin
            RDATA <= 8'h00;
        end
    end

    // Enable bits laid out in vector order
    assign en = {global_interrupt_enable[6:3], endpoint_interrupt_enable[4:0],
                 global_interrupt_enable[2:0]};

    always_comb begin
        sw_clr = '0;
        if (WR_STB && ADDR == GLOBAL_PEND) begin
            sw_clr = {WDATA[6:3], 5'b0_0000, WDATA[2:0]};
        end else if (WR_STB && ADDR == EP_PEND) begin
            sw_clr = {4'h0, WDATA[4:0], 3'b000};
        end
    end

    // Timers free-run so their phase does not depend on the enable
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            short_cnt <= 16'h0000;
        end else if (short_tick) begin
            short_cnt <= 16'h0000;
        end else begin
            short_cnt <= short_cnt + 16'h0001;
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            long_cnt <= 16'h0000;
        end else if (long_tick) begin
            long_cnt <= 16'h0000;
        end else begin
            long_cnt <= long_cnt + 16'h0001;
        end
    end

    assign short_tick = (short_cnt == 16'(SHORT_PERIOD - 1));
    assign long_tick  = (long_cnt == 16'(LONG_PERIOD - 1));

    // GPIO and handshake pins: two flops before use, third for edge detection; USB_SE0 one flop
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            gpio_s1 <= '1;
            gpio_s2 <= '1;
            gpio_s3 <= '1;
            hs_s1   <= 3'b111;
            hs_s2   <= 3'b111;
            hs_s3   <= 3'b111;
            se0_q   <= 1'b0;
        end else begin
            gpio_s1 <= GPIO_IN;
            gpio_s2 <= gpio_s1;
            gpio_s3 <= gpio_s2;
            hs_s1   <= {CHIP_SEL_N, STROBE_IN_N, OUT_EN_N};
            hs_s2   <= hs_s1;
            hs_s3   <= hs_s2;
            se0_q   <= USB_SE0;
        end
    end

    assign gpio_ev = !hs_mode && |((gpio_s2 ^ gpio_s3) & gpio_ie_flat);
    // Chip select must still be low when the release is seen
    assign hs_ev = hs_mode && !hs_s3[2] &&
                   ((hs_s2[0] && !hs_s3[0]) ||
                    (hs_s2[1] && !hs_s3[1]));

    always_comb begin
        ev                             = '0;
        ev[SRC_BUS_RESET]              = se0_q && !USB_SE0;
        ev[SRC_SHORT_TMR]              = short_tick;
        ev[SRC_LONG_TMR]               = long_tick;
        ev[SRC_EP_FIRST +: NUM_EP]     = EP_PKT_END & EP_ACKED;
        ev[SRC_HUB]                    = |(HUB_CONN_CHANGE | ((HUB_BABBLE | HUB_RESUME) & HUB_PORT_EN));
        ev[SRC_DAC]                    = DAC_EVENT;
        ev[SRC_GPIO]                   = gpio_ev || hs_ev;
        ev[SRC_SERIAL]                 = SERIAL_EVENT;
    end

    assign req     = pend & en;
    assign IRQ_REQ = |req;
    assign IRQ_OUT = |req;
    assign win_idx = lowest(req);
    assign INT_TAKEN = (state == VIC_IDLE) && INSTR_DONE && IRQ_REQ;

    always_comb begin
        take_clr = '0;
        if (INT_TAKEN) begin
            take_clr[win_idx] = 1'b1;
        end
    end

    // A new event in the clearing cycle keeps the flag set
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            pend <= '0;
        end else begin
            pend <= ev | (pend & ~(sw_clr | take_clr));
        end
    end

    // Vector sequencer: call phase, then jump phase
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state       <= VIC_BOOT;
            cnt         <= 4'h0;
            cur_idx     <= 4'h0;
            VEC_LOAD    <= 1'b0;
            VECTOR_ADDR <= BOOT_ADDR;
            ISR_BEGIN   <= 1'b0;
        end else begin
            VEC_LOAD  <= 1'b0;
            ISR_BEGIN <= 1'b0;
            case (state)
                VIC_BOOT: begin
                    VEC_LOAD    <= 1'b1;
                    VECTOR_ADDR <= BOOT_ADDR;
                    state       <= VIC_IDLE;
                end
                VIC_IDLE: begin
                    if (INT_TAKEN) begin
                        cur_idx <= win_idx;
                        cnt     <= 4'(CALL_CYCLES - 2);
                        state   <= VIC_CALL;
                    end
                end
                VIC_CALL: begin
                    if (cnt == 4'h0) begin
                        VEC_LOAD    <= 1'b1;
                        VECTOR_ADDR <= slot_addr(cur_idx);
                        cnt         <= 4'(JMP_CYCLES - 1);
                        state       <= VIC_JUMP;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                VIC_JUMP: begin
                    if (cnt == 4'h0) begin
                        ISR_BEGIN <= 1'b1;
                        state     <= VIC_IDLE;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                default: begin
                    state <= VIC_IDLE;
                end
            endcase
        end
    end

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!rst_n);

    enables_cleared_a: assert property ($rose(rst_n) |-> global_interrupt_enable == 8'h00
        && endpoint_interrupt_enable == 8'h00) else $error("enables not cleared by reset");
    boot_vector_a: assert property ($rose(rst_n) |=> VEC_LOAD && VECTOR_ADDR == 16'h0000)
        else $error("no boot vector at zero");
    latency_seq_a: assert property (INT_TAKEN |-> ##10 VEC_LOAD ##5 ISR_BEGIN)
        else $error("vector latency wrong");
    vector_addr_a: assert property (INT_TAKEN |-> ##10 VECTOR_ADDR ==
        16'((32'($past(win_idx, 10)) + 1) * 2)) else $error("vector address wrong");
    pend_hold_a: assert property (pend[SRC_DAC] && !INT_TAKEN && !(WR_STB && ADDR == GLOBAL_PEND)
        |=> pend[SRC_DAC]) else $error("pending flag lost");
    priority_win_a: assert property (INT_TAKEN && req[0] |-> win_idx == 4'h0)
        else $error("lowest vector not chosen");
    take_clear_a: assert property (INT_TAKEN && win_idx == 4'(SRC_HUB) && !ev[SRC_HUB]
        |=> !pend[SRC_HUB]) else $error("taken flag not cleared");
    req_gate_a: assert property (pend[SRC_SHORT_TMR] && !global_interrupt_enable[1]
        && !pend[SRC_BUS_RESET] && (pend[11:2] & en[11:2]) == '0 |-> !IRQ_REQ)
        else $error("request without enable");
    timer_tick_a: assert property (short_tick |=> pend[SRC_SHORT_TMR] ##1 (!short_tick)[*8])
        else $error("short timer event missing");
    bus_reset_a: assert property ($fell(USB_SE0) |-> ##1 pend[SRC_BUS_RESET])
        else $error("bus reset event missing");
    hs_block_a: assert property (hs_mode |-> !gpio_ev)
        else $error("pin interrupt during handshake mode");
    ep_nack_a: assert property (EP_PKT_END[0] && !EP_ACKED[0] && !pend[SRC_EP_FIRST]
        |=> !pend[SRC_EP_FIRST]) else $error("endpoint event without ack");
    // Each source reaches its pending flop one cycle after its event
    ie_rsvd_global_a: assert property (global_interrupt_enable[7] == 1'b0)
        else $error("reserved global enable bit set");
    ie_rsvd_ep_a: assert property (endpoint_interrupt_enable[7:5] == 3'b000)
        else $error("reserved endpoint enable bits set");
    long_tick_a: assert property (long_tick |=> pend[SRC_LONG_TMR])
        else $error("long timer event missing");
    dac_latch_a: assert property (DAC_EVENT |=> pend[SRC_DAC])
        else $error("event not latched as pending");
    ep_ack_a: assert property (EP_PKT_END[1] && EP_ACKED[1] |=> pend[SRC_EP_FIRST + 1])
        else $error("acknowledged endpoint event missing");
    hub_change_a: assert property (|HUB_CONN_CHANGE |=> pend[SRC_HUB])
        else $error("hub change event missing");
    pin_edge_a: assert property (!hs_mode && gpio_ie_flat[0] && $changed(gpio_s2[0]) |=> pend[SRC_GPIO])
        else $error("pin edge event missing");
    oe_release_a: assert property (hs_mode && !hs_s3[2] && $rose(hs_s2[0]) |=> pend[SRC_GPIO])
        else $error("output-enable release event missing");
    strobe_release_a: assert property (hs_mode && !hs_s3[2] && $rose(hs_s2[1]) |=> pend[SRC_GPIO])
        else $error("strobe release event missing");

    take_cov: cover property (INT_TAKEN ##15 ISR_BEGIN);
    gpio_cov: cover property (gpio_ev);
    hs_cov: cover property (hs_ev);
    timer_cov: cover property (long_tick);
    prio_cov: cover property (INT_TAKEN && req[SRC_DAC] && req[SRC_SERIAL]);

endmodule // vic_controller

//--- rtl/vic_pkg.sv
package vic_pkg;
    // Register map
    localparam logic [7:0] GPIO_IE_BASE   = 8'h04;
    localparam logic [7:0] GLOBAL_IE_ADDR = 8'h20;
    localparam logic [7:0] EP_IE_ADDR     = 8'h21;
    localparam logic [7:0] GLOBAL_PEND    = 8'h22;
    localparam logic [7:0] EP_PEND        = 8'h23;
    localparam logic [7:0] HS_CTRL_ADDR   = 8'h2A;
    localparam int         GPIO_PORTS     = 4;

    // Field layout and reset values
    localparam logic [7:0] GLOBAL_IE_MASK = 8'h7F;
    localparam logic [7:0] EP_IE_MASK     = 8'h1F;
    localparam logic [7:0] PORT3_IE_MASK  = 8'h7F;
    localparam logic [7:0] IE_RESET       = 8'h00;
    localparam int         HS_MODE_BIT    = 0;
    localparam int         GPIO_PINS      = 31;

    // Source index = vector number minus one
    localparam int         NUM_SRC        = 12;
    localparam int         SRC_BUS_RESET  = 0;
    localparam int         SRC_SHORT_TMR  = 1;
    localparam int         SRC_LONG_TMR   = 2;
    localparam int         SRC_EP_FIRST   = 3;
    localparam int         NUM_EP         = 5;
    localparam int         SRC_HUB        = 8;
    localparam int         SRC_DAC        = 9;
    localparam int         SRC_GPIO       = 10;
    localparam int         SRC_SERIAL     = 11;
    localparam int         NUM_HUB_PORTS  = 4;

    // Vector table
    localparam logic [15:0] BOOT_ADDR     = 16'h0000;
    localparam int          SLOT_BYTES    = 2;

    // Timing
    localparam int         CLK_MHZ          = 50;
    localparam int         SHORT_TIMER_US   = 128;
    localparam real        LONG_TIMER_MS    = 1.024;
    localparam int         SHORT_TIMER_CYC  = SHORT_TIMER_US * CLK_MHZ;
    localparam int         LONG_TIMER_CYC   = int'(LONG_TIMER_MS * 1000.0 * CLK_MHZ);
    localparam int         CALL_CYCLES      = 10;
    localparam int         JMP_CYCLES       = 5;

    typedef enum logic [1:0] {
        VIC_BOOT,
        VIC_IDLE,
        VIC_CALL,
        VIC_JUMP
    } vic_seq_t;
endpackage

//--- verif/vic_core_model.sv
module vic_core_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        stall,
    input  wire logic [3:0]  instr_len,
    input  wire logic        vec_load,
    input  wire logic [15:0] vector_addr,
    output logic             instr_done,
    output logic      [15:0] fetch_pc
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] cnt;
    logic [3:0] last;
    assign last = instr_len - 4'h1;
    // A vector can only be taken once the running instruction has spent its last cycle
    assign instr_done = !stall && (cnt == last);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 4'h0;
        end else if (cnt >= last) begin
            cnt <= 4'h0;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
    // Each two-byte slot holds one jump, so the fetch simply restarts at the slot
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fetch_pc <= 16'h0000;
        end else if (vec_load) begin
            fetch_pc <= vector_addr;
        end
    end
endmodule // vic_core_model

//--- verif/vectored_interrupt_controller_tb.sv
module vectored_interrupt_controller_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int SP = 16;
    localparam int LP = 64;
    logic        clk = 0, rst_n = 0, wr_stb = 0, rd_stb = 0, se0 = 0, dac = 0, ser = 0;
    logic        oe_n = 1, stb_n = 1, cs_n = 1, stall = 1;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, v;
    logic [4:0]  ep_end = 5'h00, ep_ack = 5'h00;
    logic [3:0]  h_conn = 4'h0, h_bab = 4'h0, h_res = 4'h0, h_en = 4'h0, len = 4'h3;
    logic [30:0] gpio = '1;
    logic        irq_req, int_taken, vec_load, isr_begin, irq_out, instr_done;
    logic [15:0] vaddr, pc;
    int          mismatches = 0, n_checks = 0, kk;

    vic_controller #(.SHORT_PERIOD(SP), .LONG_PERIOD(LP)) uut (.SYS_CLK(clk), .RESETN(rst_n),
        .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata), .USB_SE0(se0),
        .EP_PKT_END(ep_end), .EP_ACKED(ep_ack), .HUB_CONN_CHANGE(h_conn), .HUB_BABBLE(h_bab),
        .HUB_RESUME(h_res), .HUB_PORT_EN(h_en), .DAC_EVENT(dac), .SERIAL_EVENT(ser), .GPIO_IN(gpio),
        .OUT_EN_N(oe_n), .STROBE_IN_N(stb_n), .CHIP_SEL_N(cs_n), .INSTR_DONE(instr_done),
        .IRQ_REQ(irq_req), .INT_TAKEN(int_taken), .VEC_LOAD(vec_load), .VECTOR_ADDR(vaddr),
        .ISR_BEGIN(isr_begin), .IRQ_OUT(irq_out));
    vic_core_model core (.clk(clk), .rst_n(rst_n), .stall(stall), .instr_len(len), .vec_load(vec_load),
        .vector_addr(vaddr), .instr_done(instr_done), .fetch_pc(pc));

    always #10 clk = ~clk;

    task automatic print_verdict;
        $display("mismatches=%0d checks=%0d", mismatches, n_checks);
        if (mismatches == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1;
        @(posedge clk);
        wr_stb <= 0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1;
        @(posedge clk);
        rd_stb <= 0;
        #1 v = rdata;
    endtask
    task automatic hold(input logic s);
        @(posedge clk);
        stall <= s;
    endtask
    task automatic boot;
        kk = 0;
        do begin
            @(posedge clk);
            #1 kk++;
        end while (vec_load !== 1'b1 && kk < 10);
        chk(kk, 3);
        chk(vaddr, 16'h0000);
        @(posedge clk);
        #1 chk(pc, 16'h0000);
    endtask
    // Enable exactly one source; index is vector number minus one
    task automatic en(input int i);
        if (i < 3 || i > 7) begin
            wr(8'h21, 8'h00);
            wr(8'h20, 8'h01 << (i < 3 ? i : i - 5));
        end else begin
            wr(8'h20, 8'h00);
            wr(8'h21, 8'h01 << (i - 3));
        end
    endtask
    task automatic pulse(input int i);
        @(posedge clk);
        case (i)
            0: se0 <= 1;
            3, 4, 5, 6, 7: begin
                ep_end[i-3] <= 1;
                ep_ack[i-3] <= 1;
            end
            8: h_conn[0] <= 1;
            9: dac <= 1;
            10: gpio[0] <= ~gpio[0];
            11: ser <= 1;
            default: ;
        endcase
        @(posedge clk);
        se0 <= 0;
        ep_end <= 5'h00;
        ep_ack <= 5'h00;
        h_conn <= 4'h0;
        dac <= 0;
        ser <= 0;
    endtask
    // kk returns the wait before the take, so back-to-back calls measure tick spacing
    task automatic take(input logic [15:0] exp);
        int k;
        k = 0;
        // Look at the current cycle first: a take may come in the ISR_BEGIN cycle of the last one
        #1;
        while (int_taken !== 1'b1 && k < 300) begin
            @(posedge clk);
            #1 k++;
        end
        kk = k;
        k = 0;
        do begin
            @(posedge clk);
            #1 k++;
        end while (vec_load !== 1'b1 && k < 20);
        chk(k, 10);
        chk(vaddr, exp);
        do begin
            @(posedge clk);
            #1 k++;
        end while (isr_begin !== 1'b1 && k < 30);
        chk(k, 15);
        chk(pc, exp);
    endtask
    task automatic vectors;
        for (int i = 0; i < 12; i++) begin
            hold(1);
            wr(8'h22, 8'hFF);
            wr(8'h23, 8'hFF);
            en(i);
            pulse(i);
            stall <= 0;
            take(16'((i + 1) * 2));
        end
        hold(1);
        en(10);
        pulse(10);
        stall <= 0;
        take(16'h0016);
        hold(1);
        wr(8'h22, 8'hFF);
        wr(8'h20, 8'h50);
        pulse(11);
        pulse(9);
        stall <= 0;
        take(16'h0014);
        take(16'h0018);
    endtask
    task automatic timers;
        len <= 4'h1;
        hold(1);
        wr(8'h22, 8'hFF);
        en(1);
        stall <= 0;
        take(16'h0004);
        take(16'h0004);
        chk(kk, SP - 15);
        hold(1);
        wr(8'h22, 8'hFF);
        en(2);
        stall <= 0;
        take(16'h0006);
        take(16'h0006);
        chk(kk, LP - 15);
        hold(1);
    endtask
    task automatic sources;
        wr(8'h22, 8'hFF);
        wr(8'h20, 8'h00);
        pulse(9);
        #1 chk(irq_out, 1'b0);
        chk(irq_req, 1'b0);
        rd(8'h22);
        chk(v & 8'h10, 8'h10);
        wr(8'h20, 8'h10);
        #1 chk(irq_out, 1'b1);
        chk(irq_req, 1'b1);
        wr(8'h22, 8'h10);
        #1 chk(irq_out, 1'b0);
        @(posedge clk);
        ep_end <= 5'h01;
        @(posedge clk);
        ep_end <= 5'h00;
        rd(8'h23);
        chk(v, 8'h00);
        @(posedge clk);
        h_bab <= 4'h1;
        h_res <= 4'h2;
        @(posedge clk);
        h_bab <= 4'h0;
        h_res <= 4'h0;
        h_en <= 4'h1;
        rd(8'h22);
        chk(v & 8'h08, 8'h00);
        @(posedge clk);
        h_res <= 4'h1;
        @(posedge clk);
        h_res <= 4'h0;
        rd(8'h22);
        chk(v & 8'h08, 8'h08);
    endtask
    task automatic handshake;
        wr(8'h2A, 8'h01);
        wr(8'h22, 8'hFF);
        pulse(10);
        repeat (5) @(posedge clk);
        rd(8'h22);
        chk(v & 8'h20, 8'h00);
        @(posedge clk);
        cs_n <= 0;
        oe_n <= 0;
        repeat (4) @(posedge clk);
        rd(8'h22);
        chk(v & 8'h20, 8'h00);
        @(posedge clk);
        oe_n <= 1;
        repeat (5) @(posedge clk);
        rd(8'h22);
        chk(v & 8'h20, 8'h20);
        wr(8'h22, 8'h20);
        stb_n <= 0;
        repeat (4) @(posedge clk);
        stb_n <= 1;
        repeat (5) @(posedge clk);
        rd(8'h22);
        chk(v & 8'h20, 8'h20);
        cs_n <= 1;
        wr(8'h2A, 8'h00);
    endtask

    initial begin
        // Generous bound of 20000 cycles: the whole sequence needs under a thousand cycles
        #400_000;
        mismatches++;
        print_verdict();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1;
        boot();
        rd(8'h20);
        chk(v, 8'h00);
        rd(8'h21);
        chk(v, 8'h00);
        wr(8'h20, 8'hFF);
        rd(8'h20);
        chk(v, 8'h7F);
        wr(8'h21, 8'hFF);
        rd(8'h21);
        chk(v, 8'h1F);
        rd(8'h30);
        chk(v, 8'h00);
        wr(8'h21, 8'h00);
        wr(8'h04, 8'h01);
        sources();
        handshake();
        vectors();
        timers();
        rst_n <= 0;
        repeat (2) @(posedge clk);
        rst_n <= 1;
        boot();
        rd(8'h20);
        chk(v, 8'h00);
        print_verdict();
    end
endmodule // vectored_interrupt_controller_tb
